// file: design/pss_regs.sv
// Operation
// - Spread code zero off, else down amounts
// - Center mode gives symmetric same magnitude
// - Eight settings, pins pick active one
// - Frequency bit picks first/second configuration
// - Bypass bit powers down synthesizer; reset 1
// - Output eight source sixth/eighth; reset 1
// - Output nine source codes; 11 reserved
// - Pair state code sets output behaviour
// - State choice bit picks definition a/b
// - Bytes shifted most significant first
// - Reset presents listed defaults
// - Divider zero holds reset; else divides
`timescale 1ns/10ps
module pss_regs
    import pss_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rstn,
    // Avalon-MM slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // Select pins
    input  wire logic        ctrl_select_pin_a,
    input  wire logic        ctrl_select_pin_b,
    input  wire logic        ctrl_select_pin_c,
    // Center/down mode for spread
    input  wire logic        spread_center,
    // Divider values feeding the output muxes
    input  wire logic [6:0]  sixth_out_divider,
    input  wire logic [6:0]  eighth_out_divider,
    input  wire logic [6:0]  ninth_out_divider,
    // Active controls
    output logic [2:0]       synth_spread_amount,
    output logic [7:0]       spread_magnitude,
    output logic             spread_symmetric,
    output logic             synth_freq_choice,
    output logic             synth_powerdown,
    output logic [6:0]       out_eight_divisor,
    output logic             out_eight_standby,
    output logic [6:0]       out_nine_divisor,
    output logic             out_nine_standby,
    output logic [1:0]       pair_state,
    output logic             pair_drive_en,
    output logic             pair_force_low
);
    // Storage registers
    logic [23:0] spread_reg;
    logic [7:0]  freq_reg;
    logic [7:0]  bypmux_reg;
    logic [7:0]  state_sel_reg;
    // Access state: one wait cycle before each answer
    logic        ack_reg;

    // Active index from pins
    wire logic [2:0] idx = {ctrl_select_pin_c, ctrl_select_pin_b, ctrl_select_pin_a};

    // Per-setting spread fields, setting 7 in the top bits
    logic [2:0] spread_f [8];
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sp
            assign spread_f[gi] = spread_reg[gi*3 +: 3];
        end
    endgenerate

    // Decode of bus access
    wire logic access     = read | write;
    wire logic wr_go      = write & ack_reg;
    wire logic hit_sp_hi  = address == OFF_SPREAD_HI;
    wire logic hit_sp_mid = address == OFF_SPREAD_MID;
    wire logic hit_sp_lo  = address == OFF_SPREAD_LO;
    wire logic hit_freq   = address == OFF_FREQ_SEL;
    wire logic hit_bm     = address == OFF_BYP_MUX;
    wire logic hit_st     = address == OFF_STATE_SEL;
    wire logic hit_stat   = address == OFF_STATUS;
    // Writes above the limit are dropped to protect operation
    wire logic wr_ok      = wr_go & (address <= OFF_LIMIT);

    // Status word: live active selections
    wire logic [7:0] status_w = {1'b0, synth_freq_choice, pair_state, 1'b0, idx};

    // Bytes sit MSB-first in each register, setting 7 at bit 7
    wire logic [7:0] rd_mux =
        hit_sp_hi  ? spread_reg[23:16] :
        hit_sp_mid ? spread_reg[15:8]  :
        hit_sp_lo  ? spread_reg[7:0]   :
        hit_freq   ? freq_reg          :
        hit_bm     ? bypmux_reg        :
        hit_st     ? state_sel_reg     :
        hit_stat   ? status_w          : 8'h00;

    assign waitrequest = access & ~ack_reg;

    // Acknowledge toggles so each access takes two cycles
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access & ~ack_reg;
        end
    end

    // Read data registered at the wait cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            readdata <= 32'h00000000;
        end else if (read & ~ack_reg) begin
            readdata <= {24'h000000, rd_mux};
        end
    end

    // Register writes; defaults at reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            spread_reg    <= RST_SPREAD;
            freq_reg      <= RST_FREQ_SEL;
            bypmux_reg    <= RST_BYP_MUX;
            state_sel_reg <= RST_STATE_SEL;
        end else if (wr_ok) begin
            if (hit_sp_hi)  spread_reg[23:16] <= writedata[7:0];
            if (hit_sp_mid) spread_reg[15:8]  <= writedata[7:0];
            if (hit_sp_lo)  spread_reg[7:0]   <= writedata[7:0];
            if (hit_freq)   freq_reg          <= writedata[7:0];
            if (hit_bm)     bypmux_reg        <= writedata[7:0];
            if (hit_st)     state_sel_reg     <= writedata[7:0];
        end
    end

    // Active selections: spread code, pair state, output dividers and bypass
    wire logic [2:0] sp_code = spread_f[idx];
    wire logic [1:0] def_a   = bypmux_reg[POS_DEF_A +: 2];
    wire logic [1:0] def_b   = bypmux_reg[POS_DEF_B +: 2];
    wire logic [1:0] src9    = bypmux_reg[POS_OUT9 +: 2];
    wire logic [1:0] st_sel  = state_sel_reg[idx] ? def_b : def_a;
    wire logic [6:0] div8    = bypmux_reg[BIT_OUT8] ? eighth_out_divider
                                                    : sixth_out_divider;
    wire logic [6:0] div9    = (src9 == SRC9_SIXTH)  ? sixth_out_divider  :
                               (src9 == SRC9_EIGHTH) ? eighth_out_divider :
                               (src9 == SRC9_NINTH)  ? ninth_out_divider  :
                               7'h00;
    wire logic       pd_byp  = bypmux_reg[BIT_BYPASS];

    // Outputs from flip-flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            synth_spread_amount <= 3'h0;
            spread_magnitude    <= 8'h00;
            spread_symmetric    <= 1'b0;
            synth_freq_choice   <= 1'b0;
            synth_powerdown     <= 1'b1;
            out_eight_divisor   <= 7'h00;
            out_eight_standby   <= 1'b1;
            out_nine_divisor    <= 7'h00;
            out_nine_standby    <= 1'b1;
            pair_state          <= PST_HIZ_PD;
            pair_drive_en       <= 1'b0;
            pair_force_low      <= 1'b0;
        end else begin
            synth_spread_amount <= sp_code;
            spread_magnitude    <= SPREAD_TAB[sp_code];
            spread_symmetric    <= spread_center & (sp_code != 3'h0);
            synth_freq_choice   <= freq_reg[idx];
            synth_powerdown     <= pd_byp | (st_sel == PST_HIZ_PD);
            out_eight_divisor   <= div8;
            out_eight_standby   <= div8 == 7'h00;
            out_nine_divisor    <= div9;
            out_nine_standby    <= div9 == 7'h00;
            pair_state          <= st_sel;
            pair_drive_en       <= st_sel[1];
            pair_force_low      <= st_sel == PST_LOW_RUN;
        end
    end

    // First cycle of a request: still waiting
    sequence s_req_first;
        (read || write) && waitrequest;
    endsequence

    // Second cycle of a request: answered
    sequence s_req_done;
        (read || write) && !waitrequest;
    endsequence

    // Read waits exactly one cycle
    AST_WAIT_ONE: assert property (@(posedge clock) disable iff (!rstn)
        $rose(read) |-> waitrequest ##1 !waitrequest) else $error("wait not one cycle");

    // A held request is answered on the next edge
    AST_ANSWER: assert property (@(posedge clock) disable iff (!rstn)
        s_req_first |=> s_req_done) else $error("answer late");

    // The acknowledge drops after each answer
    AST_ACK_DROP: assert property (@(posedge clock) disable iff (!rstn)
        s_req_first ##1 s_req_done |=> !ack_reg) else $error("ack stuck");

    // Upper read lanes stay zero
    AST_RD_UPPER: assert property (@(posedge clock) disable iff (!rstn)
        readdata[31:8] == 24'h000000) else $error("upper lanes");

    // Top spread byte reads back in place
    AST_RD_SPREAD_HI: assert property (@(posedge clock) disable iff (!rstn)
        (read && !ack_reg && hit_sp_hi) |=> readdata[7:0] == $past(spread_reg[23:16]))
        else $error("spread readback");

    // A write to the mux register lands at the answering edge
    AST_WR_LAND: assert property (@(posedge clock) disable iff (!rstn)
        (write && !waitrequest && hit_bm) |=> bypmux_reg == $past(writedata[7:0]))
        else $error("write lost");

    // Writes above the limit leave the mux register alone
    AST_LIMIT: assert property (@(posedge clock) disable iff (!rstn)
        (write && ack_reg && address > OFF_LIMIT) |=> $stable(bypmux_reg))
        else $error("limit");

    // Bypass forces power-down
    AST_PD: assert property (@(posedge clock) disable iff (!rstn)
        bypmux_reg[BIT_BYPASS] |=> synth_powerdown) else $error("bypass not down");

    // No bypass and no powered-down state keeps the synthesizer running
    AST_RUN: assert property (@(posedge clock) disable iff (!rstn)
        (!bypmux_reg[BIT_BYPASS] && st_sel != PST_HIZ_PD) |=> !synth_powerdown)
        else $error("synthesizer down");

    // Frequency choice follows the active bit one edge later
    AST_FREQ: assert property (@(posedge clock) disable iff (!rstn)
        ##1 synth_freq_choice == $past(freq_reg[idx])) else $error("freq choice");

    // Spread code follows the active setting one edge later
    AST_SPREAD_PICK: assert property (@(posedge clock) disable iff (!rstn)
        ##1 synth_spread_amount == $past(spread_reg[idx*3 +: 3]))
        else $error("spread pick");

    // Code zero means no spread
    AST_SPREAD_OFF: assert property (@(posedge clock) disable iff (!rstn)
        synth_spread_amount == 3'h0 |-> spread_magnitude == 8'h00) else $error("spread off");

    // Largest code gives the top amount
    AST_SPREAD_MAX: assert property (@(posedge clock) disable iff (!rstn)
        synth_spread_amount == 3'h7 |-> spread_magnitude == SPREAD_TAB[7])
        else $error("spread max");

    // Symmetric flag needs a nonzero code
    AST_CENTER: assert property (@(posedge clock) disable iff (!rstn)
        spread_symmetric |-> synth_spread_amount != 3'h0) else $error("center zero");

    // Center mode with a live code turns on symmetric spread
    AST_CENTER_ON: assert property (@(posedge clock) disable iff (!rstn)
        (spread_center && sp_code != 3'h0) |=> spread_symmetric) else $error("center off");

    // Output eight source follows its select bit
    AST_OUT8_HI: assert property (@(posedge clock) disable iff (!rstn)
        bypmux_reg[BIT_OUT8] |=> out_eight_divisor == $past(eighth_out_divider))
        else $error("out8 eighth");

    AST_OUT8_LO: assert property (@(posedge clock) disable iff (!rstn)
        !bypmux_reg[BIT_OUT8] |=> out_eight_divisor == $past(sixth_out_divider))
        else $error("out8 sixth");

    // Output nine source follows its code
    AST_OUT9_SIXTH: assert property (@(posedge clock) disable iff (!rstn)
        src9 == SRC9_SIXTH |=> out_nine_divisor == $past(sixth_out_divider))
        else $error("out9 sixth");

    AST_OUT9_EIGHTH: assert property (@(posedge clock) disable iff (!rstn)
        src9 == SRC9_EIGHTH |=> out_nine_divisor == $past(eighth_out_divider))
        else $error("out9 eighth");

    AST_OUT9_NINTH: assert property (@(posedge clock) disable iff (!rstn)
        src9 == SRC9_NINTH |=> out_nine_divisor == $past(ninth_out_divider))
        else $error("out9 ninth");

    // Reserved code parks output nine in standby
    AST_OUT9_RSVD: assert property (@(posedge clock) disable iff (!rstn)
        src9 == 2'h3 |=> out_nine_standby) else $error("out9 reserved");

    // Standby flags track a zero divisor
    AST_STBY8: assert property (@(posedge clock) disable iff (!rstn)
        out_eight_standby == (out_eight_divisor == 7'h00)) else $error("standby8");

    AST_STBY9: assert property (@(posedge clock) disable iff (!rstn)
        out_nine_standby == (out_nine_divisor == 7'h00)) else $error("standby9");

    // State choice picks definition b or a
    AST_STATE_B: assert property (@(posedge clock) disable iff (!rstn)
        state_sel_reg[idx] |=> pair_state == $past(def_b)) else $error("state b");

    AST_STATE_A: assert property (@(posedge clock) disable iff (!rstn)
        !state_sel_reg[idx] |=> pair_state == $past(def_a)) else $error("state a");

    // Low drive implies driving
    AST_LOW: assert property (@(posedge clock) disable iff (!rstn)
        pair_force_low |-> pair_drive_en == 1'b1) else $error("low not driven");

    // Tri-state codes never drive
    AST_HIZ: assert property (@(posedge clock) disable iff (!rstn)
        !pair_state[1] |-> !pair_drive_en && !pair_force_low) else $error("hiz driven");

    // Normal code drives the clock, not a low level
    AST_NORMAL: assert property (@(posedge clock) disable iff (!rstn)
        pair_state == PST_NORMAL |-> pair_drive_en && !pair_force_low) else $error("normal");

    // Powered-down state code stops the synthesizer
    AST_PAIR_PD: assert property (@(posedge clock) disable iff (!rstn)
        pair_state == PST_HIZ_PD |-> synth_powerdown) else $error("state not down");
endmodule : pss_regs

// file: shared/pss_pkg.sv
package pss_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_SPREAD_HI   = 8'h40;
    localparam logic [7:0] OFF_SPREAD_MID  = 8'h41;
    localparam logic [7:0] OFF_SPREAD_LO   = 8'h42;
    localparam logic [7:0] OFF_FREQ_SEL    = 8'h43;
    localparam logic [7:0] OFF_BYP_MUX     = 8'h44;
    localparam logic [7:0] OFF_STATE_SEL   = 8'h45;
    localparam logic [7:0] OFF_STATUS      = 8'h48;
    localparam logic [7:0] OFF_LIMIT       = 8'h50;
    // Reset values
    localparam logic [23:0] RST_SPREAD     = 24'h000000;
    localparam logic [7:0]  RST_FREQ_SEL   = 8'h00;
    localparam logic [7:0]  RST_BYP_MUX    = 8'hed;
    localparam logic [7:0]  RST_STATE_SEL  = 8'h02;
    // Field positions in bypass/mux register
    localparam int BIT_BYPASS   = 7;
    localparam int BIT_OUT8     = 6;
    localparam int POS_OUT9     = 4;
    localparam int POS_DEF_B    = 2;
    localparam int POS_DEF_A    = 0;
    // Output-nine source codes
    localparam logic [1:0] SRC9_SIXTH   = 2'h0;
    localparam logic [1:0] SRC9_EIGHTH  = 2'h1;
    localparam logic [1:0] SRC9_NINTH   = 2'h2;
    // Output state codes
    typedef enum logic [1:0] {
        PST_HIZ_PD  = 2'h0,
        PST_HIZ_RUN = 2'h1,
        PST_LOW_RUN = 2'h2,
        PST_NORMAL  = 2'h3
    } pss_state_e;
    // Spread amounts in hundredths of a percent, per code
    localparam logic [7:0] SPREAD_TAB [8] = '{8'h00, 8'h19, 8'h32, 8'h4b,
                                             8'h64, 8'h7d, 8'h96, 8'hc8};
endpackage : pss_pkg

// file: tb/pss_pin_model.sv
`timescale 1ns/10ps
// Control-select pins as a board would drive them
module pss_pin_model (
    input  wire logic [2:0] index_req,
    input  wire logic       clock,
    output logic            ctrl_select_pin_a,
    output logic            ctrl_select_pin_b,
    output logic            ctrl_select_pin_c
);
    // Defined levels before the first edge
    initial {ctrl_select_pin_c, ctrl_select_pin_b, ctrl_select_pin_a} = 3'h0;
    // Pins move just after an edge; index bit 2 lands on pin c
    always @(posedge clock) begin
        ctrl_select_pin_a <= index_req[0];
        ctrl_select_pin_b <= index_req[1];
        ctrl_select_pin_c <= index_req[2];
    end
endmodule : pss_pin_model

// file: tb/test_pss_regs.sv
`timescale 1ns/10ps
module test_pss_regs
    import pss_pkg::*;
;
    logic clock, rstn, read, write, spread_center, sample;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [2:0]  index_req;      // Setting asked of the pin model
    logic [6:0]  sixth_out_divider, eighth_out_divider, ninth_out_divider;
    wire  [31:0] readdata;
    wire  waitrequest, ctrl_select_pin_a, ctrl_select_pin_b, ctrl_select_pin_c;
    wire  [2:0] synth_spread_amount;
    wire  [7:0] spread_magnitude;
    wire  spread_symmetric, synth_freq_choice, synth_powerdown, out_eight_standby;
    wire  out_nine_standby, pair_drive_en, pair_force_low;
    wire  [6:0] out_eight_divisor, out_nine_divisor;
    wire  [1:0] pair_state;
    logic [7:0]  sh [6];         // Shadow of registers 0x40..0x45
    logic [33:0] rd_q [$];       // Expected read data
    logic [33:0] out_q [$];      // Expected packed outputs
    int miscompares, checks;

    pss_regs DUT (.clock, .rstn, .address, .read, .write, .writedata, .readdata,
        .waitrequest, .ctrl_select_pin_a, .ctrl_select_pin_b, .ctrl_select_pin_c,
        .spread_center, .sixth_out_divider, .eighth_out_divider, .ninth_out_divider,
        .synth_spread_amount, .spread_magnitude, .spread_symmetric, .synth_freq_choice,
        .synth_powerdown, .out_eight_divisor, .out_eight_standby, .out_nine_divisor,
        .out_nine_standby, .pair_state, .pair_drive_en, .pair_force_low);
    pss_pin_model PINS (.index_req, .clock, .ctrl_select_pin_a, .ctrl_select_pin_b,
        .ctrl_select_pin_c);

    // Clock of 50 ns period
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Expected controls for the active setting
    function automatic logic [33:0] exp_out();
        logic [2:0] code;
        logic [1:0] st;
        logic [6:0] o8, o9;
        code = 3'({sh[0], sh[1], sh[2]} >> (3 * index_req));
        st = sh[5][index_req] ? sh[4][3:2] : sh[4][1:0];
        o8 = sh[4][6] ? eighth_out_divider : sixth_out_divider;
        o9 = sh[4][5:4] == 2'h0 ? sixth_out_divider : sh[4][5:4] == 2'h1 ?
             eighth_out_divider : sh[4][5:4] == 2'h2 ? ninth_out_divider : 7'h00;
        return {code, (code == 3'h7) ? 8'hc8 : 8'(code * 25),
                spread_center && code != 3'h0, sh[3][index_req],
                sh[4][7] || st == 2'h0, o8, o8 == 7'h00, o9, o9 == 7'h00,
                st, st[1], st == 2'h2};
    endfunction : exp_out

    // Count and report one comparison
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One Avalon request, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= {24'h0, d};
        do @(posedge clock); while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    // Register write that keeps the shadow in step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a >= 8'h40 && a <= 8'h45) sh[a[2:0]] = d;
        bus(1'b1, a, d);
    endtask : wr

    // Register read; unmapped places read zero
    task automatic rd(input logic [7:0] a);
        rd_q.push_back((a >= 8'h40 && a <= 8'h45) ? {26'h0, sh[a[2:0]]} : 34'h0);
        bus(1'b0, a, 8'h00);
    endtask : rd

    // Let pins and outputs settle, then sample once
    task automatic chk_out();
        repeat (3) @(posedge clock);
        out_q.push_back(exp_out());
        sample <= 1'b1;
        @(posedge clock);
        sample <= 1'b0;
    endtask : chk_out

    // Watch outputs and match them to the oldest note
    always @(posedge clock) begin
        if (read && waitrequest === 1'b0) check({2'h0, readdata}, rd_q.pop_front());
        if (sample) check({synth_spread_amount, spread_magnitude, spread_symmetric,
            synth_freq_choice, synth_powerdown, out_eight_divisor, out_eight_standby,
            out_nine_divisor, out_nine_standby, pair_state, pair_drive_en,
            pair_force_low}, out_q.pop_front());
    end

    // Counts, verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // Hang guard well beyond the expected run
    initial begin
        #150000;
        miscompares++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        {rstn, read, write, spread_center, sample, index_req, address} = '0;
        writedata = '0;
        {sixth_out_divider, eighth_out_divider, ninth_out_divider} = {7'h01, 7'h02, 7'h03};
        sh = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hed, 8'h02};
        void'($urandom(52));
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        for (int a = 0; a < 6; a++) rd(8'h40 + 8'(a));
        chk_out();
        wr(8'h40, 8'hfa);
        wr(8'h41, 8'hc6);
        wr(8'h42, 8'h88);
        wr(8'h43, 8'($urandom));
        wr(8'h45, 8'($urandom));
        for (int i = 0; i < 8; i++) begin
            index_req <= 3'(i);
            spread_center <= 1'($urandom);
            chk_out();
        end
        for (int c = 0; c < 4; c++) begin
            wr(8'h44, {1'($urandom), 1'(c), 2'(c % 3), 2'(c), ~2'(c)});
            sixth_out_divider <= (c == 1) ? 7'h00 : 7'($urandom);
            eighth_out_divider <= 7'($urandom);
            ninth_out_divider <= (c == 2) ? 7'h00 : 7'($urandom);
            for (int k = 0; k < 2; k++) begin
                index_req <= 3'($urandom);
                chk_out();
            end
        end
        wr(8'h51, 8'hff);
        for (int a = 0; a < 7; a++) rd(8'h40 + 8'(a));
        report_and_stop();
    end
endmodule : test_pss_regs
